// ### core/vac_map.vh
`ifndef VAC_MAP_VH
`define VAC_MAP_VH
// Register byte offsets
`define VAC_CTRL_OFS      12'h000
`define VAC_CMD_OFS       12'h004
`define VAC_STATUS_OFS    12'h008
`define VAC_SIMVAL_OFS    12'h00c
`define VAC_RAMP_OFS      12'h010
`define VAC_STEP_OFS      12'h014
`define VAC_DIRECT_OFS    12'h018
`define VAC_CMDVAL_OFS    12'h01c
`define VAC_CURA_OFS      12'h020
`define VAC_CURB_OFS      12'h024
`define VAC_AIN_OFS       12'h028
`define VAC_DIO_OFS       12'h02c
// CTRL fields
`define VAC_CTRL_ONLINE   0
`define VAC_CTRL_SIMEN    1
`define VAC_CTRL_SOLB     2
// CMD write-one strobes
`define VAC_CMD_TAKEOVER  0
`define VAC_CMD_HANDBACK  1
`define VAC_CMD_ENABLE    2
`define VAC_CMD_DISABLE   3
`define VAC_CMD_STEPUP    4
`define VAC_CMD_STEPDN    5
`define VAC_CMD_START     6
`define VAC_CMD_STOP      7
// STATUS fields
`define VAC_ST_REMOTE     0
`define VAC_ST_ACTIVE     1
`define VAC_ST_RUN        2
`define VAC_ST_REJECT     3
// Scaling: command in 0.1 % units, full scale 1000
`define VAC_FULL_SCALE    12'sd1000
`define VAC_CUR_MAX       10'd1000
// Ramp time step 0.05 s in ns, clock 20 ns
`define VAC_RAMP_STEP_NS  50000000
`define VAC_CLK_NS        20
`define VAC_RAMP_MAX      14'd10000
// Reset values
`define VAC_CTRL_RST      3'h0
`define VAC_RAMP_RST      14'h0000
`endif

// ### core/vac_ramp.v
`timescale 1ns/10ps
`include "vac_map.vh"
// Linear ramp of the active command toward its target
module vac_ramp #(
	parameter TICK_CYC = 2500
)
(
	input  wire               core_clk_in,
	input  wire               resetn_in,
	input  wire signed [11:0] target_in,
	input  wire        [13:0] ramp_in,
	output reg  signed [11:0] value_out
);
	// Cycles per 0.1 % count for one ramp unit; dividing first keeps the product in 32 bits
	// at the longest ramp, so TICK_CYC must be a multiple of 1000
	localparam [31:0] STEP_CYC = TICK_CYC / 1000;
	// One 0.1 % step per (ramp * 0.05 s / 1000) interval
	reg [31:0] pace_ff;
	wire [31:0] period = {18'h00000, ramp_in} * STEP_CYC;
	always @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			pace_ff   <= 32'h0;
			value_out <= 12'sh000;
		end
		else if (value_out == target_in)
			pace_ff <= 32'h0;
		else if (ramp_in == 14'h0)
			value_out <= target_in;  // Zero ramp: jump directly
		else if (pace_ff + 32'h1 >= period)
		begin
			pace_ff <= 32'h0;
			if (value_out < target_in)  // Linear ramp toward target
				value_out <= value_out + 12'sd1;
			else
				value_out <= value_out - 12'sd1;
		end
		else
			pace_ff <= pace_ff + 32'h1;
	end
endmodule

// ### core/vac_ctrl.v
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "vac_map.vh"
// Function
// - Simulation, direct operation, enable commands need online plus remote host mode.
// - Disabling simulation holds the last command value, not zero.
// - Command spans -100..100 % in 0.1 %, magnitude maps to Imin..Imax; SIMVAL writes are not clamped to the span, only the current saturates.
// - Positive drives solenoid A, negative solenoid B, zero is Imin A.
// - Command moves along a linear ramp; ramp time per full 0..100 %.
// - Step up adds signed step, step down subtracts it.
// - Direct operation current setpoint is a percent of Imin..Imax.
// - Start applies set current to selected solenoid; stop removes it.
// - Solenoid select routes direct current to A or B.
// - Mode changes only while online and disabled.
// - Takeover from local enters remote host mode, ignoring local inputs.
// - Hand-back from remote enters local mode; direct operation refused.
// - Enable command enters active state.
// - Disable command enters disabled state.
// - Digital inputs and outputs read back one bit each.
// - While online, readback values are refreshed continually.
module vac_ctrl
(
	input  wire        core_clk_in,
	input  wire        resetn_in,
	input  wire [11:0] paddr_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	input  wire [11:0] local_cmd_in,
	input  wire        local_en_in,
	input  wire [11:0] ain_in,
	input  wire [9:0]  meas_a_in,
	input  wire [9:0]  meas_b_in,
	input  wire [7:0]  din_in,
	input  wire [7:0]  dout_in,
	output reg  [9:0]  cur_a_out,
	output reg  [9:0]  cur_b_out,
	output reg         active_out
);
	localparam TICK_CYC = `VAC_RAMP_STEP_NS / `VAC_CLK_NS;
	// Control states, one-hot
	localparam ST_LOCAL  = 2'b01;
	localparam ST_REMOTE = 2'b10;

	reg  [1:0]         mode_ff;
	reg  [1:0]         nxt_mode;
	reg  [2:0]         ctrl_ff;
	reg  signed [11:0] simval_ff;
	reg  signed [11:0] nxt_simval;
	reg  [13:0]        ramp_ff;
	reg  signed [11:0] step_ff;
	reg  [9:0]         direct_ff;
	reg                run_ff;
	reg                nxt_run;
	reg                act_ff;
	reg                nxt_act;
	reg                rej_ff;
	reg                nxt_rej;
	reg  signed [11:0] hold_ff;
	reg  [11:0]        ain_ff;
	reg  [9:0]         meas_a_ff;
	reg  [9:0]         meas_b_ff;
	reg  [15:0]        dio_ff;
	reg  [31:0]        rdata;
	reg                rerr;
	wire signed [11:0] ramped;
	wire signed [12:0] sum_up;
	wire signed [12:0] sum_dn;
	wire signed [11:0] cmd_src;
	wire [11:0]        mag;
	wire [9:0]         scaled;

	wire remote  = mode_ff[1];
	wire online  = ctrl_ff[`VAC_CTRL_ONLINE];
	wire simen   = ctrl_ff[`VAC_CTRL_SIMEN];
	wire acc     = psel_in & penable_in & ~pready_out;
	wire wr      = psel_in & penable_in & pready_out & pwrite_in;  // Lands at the completing edge
	wire host_ok = online & remote;  // Host commands gated by mode
	wire cmd_wr  = wr & (paddr_in == `VAC_CMD_OFS);
	wire [7:0] cmd = cmd_wr ? pwdata_in[7:0] : 8'h00;

	// Saturating step arithmetic within full scale
	assign sum_up = {simval_ff[11], simval_ff} + {step_ff[11], step_ff};
	assign sum_dn = {simval_ff[11], simval_ff} - {step_ff[11], step_ff};

	// Mode, enable, direct run and rejection logic
	always @*
	begin
		nxt_mode   = mode_ff;
		nxt_act    = act_ff;
		nxt_run    = run_ff;
		nxt_rej    = rej_ff;
		nxt_simval = simval_ff;
		if (cmd_wr)
			nxt_rej = 1'b0;
		case (mode_ff)
			ST_LOCAL:
			begin
				if (cmd[`VAC_CMD_TAKEOVER] & online & ~act_ff)
					nxt_mode = ST_REMOTE;  // Takeover into host mode
				if (cmd[`VAC_CMD_TAKEOVER] & ~(online & ~act_ff))
					nxt_rej = 1'b1;
				if (cmd[`VAC_CMD_HANDBACK] | cmd[`VAC_CMD_ENABLE] | cmd[`VAC_CMD_DISABLE]
					| cmd[`VAC_CMD_STEPUP] | cmd[`VAC_CMD_STEPDN] | cmd[`VAC_CMD_START]
					| cmd[`VAC_CMD_STOP])
					nxt_rej = 1'b1;  // Direct operation refused locally
				nxt_run = 1'b0;
			end
			ST_REMOTE:
			begin
				if (cmd[`VAC_CMD_HANDBACK] & online & ~act_ff)
				begin
					nxt_mode = ST_LOCAL;  // Hand back to local
					nxt_run  = 1'b0;
				end
				if ((cmd[`VAC_CMD_HANDBACK] & ~(online & ~act_ff))
					| (cmd[`VAC_CMD_TAKEOVER]) | (|cmd[7:2] & ~online))
					nxt_rej = 1'b1;
				if (cmd[`VAC_CMD_ENABLE] & online)
					nxt_act = 1'b1;
				if (cmd[`VAC_CMD_DISABLE] & online)
					nxt_act = 1'b0;
				if (cmd[`VAC_CMD_START] & online)
					nxt_run = 1'b1;
				if (cmd[`VAC_CMD_STOP] & online)
					nxt_run = 1'b0;
				if (cmd[`VAC_CMD_STEPUP] & online)  // Signed step, clamped both ways
					nxt_simval = (sum_up > 13'sd1000) ? `VAC_FULL_SCALE
						: ((sum_up < -13'sd1000) ? -`VAC_FULL_SCALE : sum_up[11:0]);
				if (cmd[`VAC_CMD_STEPDN] & online)
					nxt_simval = (sum_dn < -13'sd1000) ? -`VAC_FULL_SCALE
						: ((sum_dn > 13'sd1000) ? `VAC_FULL_SCALE : sum_dn[11:0]);
			end
			default:
			begin
				nxt_mode = ST_LOCAL;
				nxt_run  = 1'b0;
			end
		endcase
		if (remote == 1'b0)
			nxt_act = local_en_in;  // Local input drives enable
		if (wr & (paddr_in == `VAC_SIMVAL_OFS))
		begin
			if (host_ok)
				nxt_simval = $signed(pwdata_in[11:0]);
			else
				nxt_rej = 1'b1;
		end
	end

	// State and settings registers
	always @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			mode_ff   <= ST_LOCAL;
			ctrl_ff   <= `VAC_CTRL_RST;
			simval_ff <= 12'sh000;
			ramp_ff   <= `VAC_RAMP_RST;
			step_ff   <= 12'sh000;
			direct_ff <= 10'h000;
			run_ff    <= 1'b0;
			act_ff    <= 1'b0;
			rej_ff    <= 1'b0;
		end
		else
		begin
			mode_ff   <= nxt_mode;
			act_ff    <= nxt_act;
			run_ff    <= nxt_run;
			rej_ff    <= nxt_rej;
			simval_ff <= nxt_simval;
			if (wr & (paddr_in == `VAC_CTRL_OFS))
				ctrl_ff <= pwdata_in[2:0];  // Online, sim enable and solenoid select
			if (wr & (paddr_in == `VAC_RAMP_OFS))
				ramp_ff <= (pwdata_in[13:0] > `VAC_RAMP_MAX) ? `VAC_RAMP_MAX : pwdata_in[13:0];
			if (wr & (paddr_in == `VAC_STEP_OFS))
				step_ff <= pwdata_in[11:0];
			if (wr & (paddr_in == `VAC_DIRECT_OFS) & host_ok)
				direct_ff <= (pwdata_in[9:0] > `VAC_CUR_MAX) ? `VAC_CUR_MAX : pwdata_in[9:0];
		end
	end

	// Source for the ramp: sim value, held value or local input
	assign cmd_src = ~remote ? $signed(local_cmd_in) : (simen ? simval_ff : hold_ff);

	vac_ramp #(.TICK_CYC(TICK_CYC)) u_ramp
	(
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.target_in   (cmd_src),
		.ramp_in     (ramp_ff),
		.value_out   (ramped)
	);

	// Magnitude scaled to Imin..Imax span in 0.1 %
	assign mag    = ramped[11] ? (12'h000 - ramped) : ramped;
	assign scaled = (mag > 12'd1000) ? `VAC_CUR_MAX : mag[9:0];

	// Held command, solenoid outputs and sampled readback
	always @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			hold_ff    <= 12'sh000;
			cur_a_out  <= 10'h000;
			cur_b_out  <= 10'h000;
			active_out <= 1'b0;
			ain_ff     <= 12'h000;
			meas_a_ff  <= 10'h000;
			meas_b_ff  <= 10'h000;
			dio_ff     <= 16'h0000;
		end
		else
		begin
			if (simen)
				hold_ff <= ramped;  // Last active value kept on sim off
			active_out <= act_ff;
			if (~act_ff)
			begin
				cur_a_out <= 10'h000;
				cur_b_out <= 10'h000;
			end
			else if (remote & run_ff)  // Direct current to chosen solenoid
			begin
				cur_a_out <= ctrl_ff[`VAC_CTRL_SOLB] ? 10'h000 : direct_ff;
				cur_b_out <= ctrl_ff[`VAC_CTRL_SOLB] ? direct_ff : 10'h000;
			end
			else
			begin
				cur_a_out <= ramped[11] ? 10'h000 : scaled;  // Zero is Imin A
				cur_b_out <= ramped[11] ? scaled : 10'h000;
			end
			if (online)  // Refresh readback every cycle
			begin
				ain_ff    <= ain_in;
				meas_a_ff <= meas_a_in;
				meas_b_ff <= meas_b_in;
				dio_ff    <= {dout_in, din_in};  // One bit per pin
			end
		end
	end

	// Read mux
	always @*
	begin
		rdata = 32'h0;
		rerr  = 1'b0;
		case (paddr_in)
			`VAC_CTRL_OFS:   rdata = {29'h0, ctrl_ff};
			`VAC_CMD_OFS:    rdata = 32'h0;
			`VAC_STATUS_OFS: rdata = {28'h0, rej_ff, run_ff, act_ff, remote};
			`VAC_SIMVAL_OFS: rdata = {20'h0, simval_ff};
			`VAC_RAMP_OFS:   rdata = {18'h0, ramp_ff};
			`VAC_STEP_OFS:   rdata = {20'h0, step_ff};
			`VAC_DIRECT_OFS: rdata = {22'h0, direct_ff};
			`VAC_CMDVAL_OFS: rdata = {20'h0, ramped};
			`VAC_CURA_OFS:   rdata = {12'h0, meas_a_ff, cur_a_out};
			`VAC_CURB_OFS:   rdata = {12'h0, meas_b_ff, cur_b_out};
			`VAC_AIN_OFS:    rdata = {20'h0, ain_ff};
			`VAC_DIO_OFS:    rdata = {16'h0, dio_ff};
			default:         rerr  = 1'b1;
		endcase
	end

	// APB answer: one wait state, registered
	always @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0;
		end
		else
		begin
			pready_out  <= acc;
			pslverr_out <= acc & rerr;
			prdata_out  <= (acc & ~pwrite_in) ? rdata : 32'h0;
		end
	end
endmodule

// ### tb/vac_ctrl_chk.sv
`timescale 1ns/10ps
// Watches the controller ports for bus and solenoid output faults
module vac_ctrl_chk
(
	input wire		core_clk_in,
	input wire		resetn_in,
	input wire [11:0]	paddr_in,
	input wire		psel_in,
	input wire		penable_in,
	input wire		pready_out,
	input wire		pslverr_out,
	input wire [9:0]	cur_a_out,
	input wire [9:0]	cur_b_out,
	input wire		active_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_rdy_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	a_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("access not answered after one wait");
	a_rdy_cause: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("pready without access");
	a_err_unmap: assert property (pslverr_out |-> pready_out && (paddr_in > 12'h02c ||
		paddr_in[1:0] != 2'b00))
		else $error("error on mapped address");
	a_map_ok: assert property (pready_out && paddr_in <= 12'h02c && paddr_in[1:0] == 2'b00
		|-> !pslverr_out)
		else $error("mapped access refused");
	a_cur_range: assert property (cur_a_out <= 10'd1000 && cur_b_out <= 10'd1000)
		else $error("current beyond full scale");
	a_one_sol: assert property (cur_a_out == 10'd0 || cur_b_out == 10'd0)
		else $error("both solenoids driven");
	a_off_zero: assert property (!active_out [*2] |-> cur_a_out == 10'd0 &&
		cur_b_out == 10'd0)
		else $error("current while disabled");
endmodule

bind vac_ctrl vac_ctrl_chk u_chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
	.paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .cur_a_out(cur_a_out),
	.cur_b_out(cur_b_out), .active_out(active_out));

// ### tb/vac_field_model.sv
`timescale 1ns/10ps
// Field side: coils follow the commanded current, pins sit at fixed levels
module vac_field_model
(
	input wire		core_clk_in,
	input wire [9:0]	cur_a_in,
	input wire [9:0]	cur_b_in,
	output reg [9:0]	meas_a_out,
	output reg [9:0]	meas_b_out,
	output wire [11:0]	ain_out,
	output wire [7:0]	din_out,
	output wire [7:0]	dout_out
);
	// Coil current settles one cycle after its command
	always @(posedge core_clk_in)
	begin
		meas_a_out <= cur_a_in;
		meas_b_out <= cur_b_in;
	end
	// Fixed analogue and digital pin levels
	assign ain_out = 12'h3a5;
	assign din_out = 8'h5a;
	assign dout_out = 8'hc3;
endmodule

// ### tb/test_valve_amp_remote_command_ctrl.sv
`timescale 1ns/10ps
module test_valve_amp_remote_command_ctrl;
	reg		core_clk_in = 0;
	reg		resetn_in = 0;
	reg [11:0]	paddr_in = 0;
	reg		psel_in = 0;
	reg		penable_in = 0;
	reg		pwrite_in = 0;
	reg [31:0]	pwdata_in = 0;
	reg		local_en_in = 0;
	reg [11:0]	local_cmd_in = 12'h12c;
	wire [31:0]	prdata_out;
	wire		pready_out;
	wire		pslverr_out;
	wire		active_out;
	wire [9:0]	cur_a_out;
	wire [9:0]	cur_b_out;
	wire [9:0]	meas_a_in;
	wire [9:0]	meas_b_in;
	wire [11:0]	ain_in;
	wire [7:0]	din_in;
	wire [7:0]	dout_in;
	reg [31:0]	rd_q;
	reg		err_q;
	integer		num_errors = 0;
	integer		check_count = 0;
	integer		cyc = 0;
	vac_ctrl u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .paddr_in(paddr_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .local_cmd_in(local_cmd_in), .local_en_in(local_en_in),
		.ain_in(ain_in), .meas_a_in(meas_a_in), .meas_b_in(meas_b_in), .din_in(din_in),
		.dout_in(dout_in), .cur_a_out(cur_a_out), .cur_b_out(cur_b_out),
		.active_out(active_out));
	vac_field_model u_fld (.core_clk_in(core_clk_in), .cur_a_in(cur_a_out),
		.cur_b_in(cur_b_out), .meas_a_out(meas_a_in), .meas_b_out(meas_b_in),
		.ain_out(ain_in), .din_out(din_in), .dout_out(dout_in));
	// Clock and hang guard
	always #10 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			test_done;
		end
	end
	task test_done;
	begin
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task chk(input [8*6:1] what, input [31:0] e, input [31:0] g);
	begin
		check_count = check_count + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %0s exp %h got %h", what, e, g);
		end
	end
	endtask
	// One bus transfer, held until pready is seen at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		@(posedge core_clk_in);
		while (pready_out !== 1'b1)
			@(posedge core_clk_in);
		rd_q = prdata_out;
		err_q = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	end
	endtask
	task w(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task r(input [11:0] a, input [31:0] e);
	begin
		apb(1'b0, a, 32'h0);
		chk("reg", e, rd_q);
	end
	endtask
	task tk(input integer n);
		repeat (n) @(posedge core_clk_in);
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		r(12'h008, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk("slverr", 32'h1, {31'h0, err_q});
		w(12'h004, 32'h1);
		r(12'h008, 32'h8);
		w(12'h000, 32'h1);
		w(12'h004, 32'h1);
		r(12'h008, 32'h1);
		w(12'h004, 32'h1);
		r(12'h008, 32'h9);
		w(12'h004, 32'h4);
		r(12'h008, 32'h3);
		w(12'h004, 32'h2);
		r(12'h008, 32'hb);
		w(12'h010, 32'h0);
		w(12'h000, 32'h3);
		w(12'h00c, 32'h1f4);
		tk(8);
		chk("cur_a", 32'd500, {22'h0, cur_a_out});
		w(12'h00c, 32'hfffffed4);
		tk(8);
		chk("cur_b", 32'd300, {22'h0, cur_b_out});
		w(12'h014, 32'h64);
		w(12'h004, 32'h10);
		tk(8);
		apb(1'b0, 12'h01c, 32'h0);
		chk("cmd", 32'hf38, {20'h0, rd_q[11:0]});
		w(12'h004, 32'h20);
		apb(1'b0, 12'h01c, 32'h0);
		chk("cmd", 32'hed4, {20'h0, rd_q[11:0]});
		w(12'h004, 32'h10);
		w(12'h000, 32'h1);
		tk(8);
		chk("cur_b", 32'd200, {22'h0, cur_b_out});
		w(12'h010, 32'h1);
		w(12'h000, 32'h3);
		w(12'h00c, 32'h0);
		// One ramp unit over full scale: one 0.1 % count every 2500 cycles
		tk(100);
		chk("ramp", 32'd200, {22'h0, cur_b_out});
		tk(2500);
		chk("ramp", 32'd199, {22'h0, cur_b_out});
		tk(2500);
		chk("ramp", 32'd198, {22'h0, cur_b_out});
		w(12'h010, 32'h0);
		tk(8);
		chk("cur_b", 32'h0, {22'h0, cur_b_out});
		w(12'h018, 32'h190);
		w(12'h000, 32'h5);
		w(12'h004, 32'h40);
		tk(8);
		chk("cur_b", 32'd400, {22'h0, cur_b_out});
		r(12'h024, 32'h00064190);
		w(12'h004, 32'h80);
		tk(8);
		chk("cur_b", 32'h0, {22'h0, cur_b_out});
		w(12'h000, 32'h1);
		w(12'h018, 32'hfa);
		w(12'h004, 32'h40);
		tk(8);
		chk("cur_a", 32'd250, {22'h0, cur_a_out});
		r(12'h020, 32'h0003e8fa);
		w(12'h004, 32'h80);
		w(12'h004, 32'h8);
		tk(4);
		chk("active", 32'h0, {31'h0, active_out});
		w(12'h004, 32'h2);
		r(12'h008, 32'h0);
		w(12'h004, 32'h40);
		r(12'h008, 32'h8);
		local_en_in <= 1'b1;
		tk(8);
		chk("active", 32'h1, {31'h0, active_out});
		chk("cur_a", 32'd300, {22'h0, cur_a_out});
		w(12'h00c, 32'h5);
		r(12'h008, 32'ha);
		r(12'h02c, 32'h0000c35a);
		r(12'h028, 32'h000003a5);
		test_done;
	end
endmodule
